// file: design/cpg_pkg.sv
package cpg_pkg;
  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] PER_OFS = 8'h04;
  localparam logic [7:0] DUTY_OFS = 8'h08;
  localparam logic [7:0] DTP_OFS = 8'h0C;
  localparam logic [7:0] DTA_OFS = 8'h10;
  localparam logic [7:0] IOC_OFS = 8'h14;
  localparam logic [7:0] STAT_OFS = 8'h18;
  localparam logic [7:0] ICLR_OFS = 8'h1C;
  localparam logic [7:0] IEN_OFS = 8'h20;
  localparam logic [7:0] CNT_OFS = 8'h24;
  // ==========================================================================
  // Control fields
  localparam int CTRL_IMM_BIT = 0;
  localparam int CTRL_XRES_BIT = 1;
  localparam int CTRL_CENTER_BIT = 2;
  localparam int CTRL_ITB_BIT = 9;
  localparam int CTRL_EN_BIT = 15;
  // Output control fields
  localparam int IOC_SYNC_BIT = 0;
  localparam int IOC_OVD_LSB = 6;
  localparam int IOC_OVEN_LSB = 8;
  // Status / interrupt bits
  localparam int IRQ_PERIOD_BIT = 0;
  localparam int IRQ_XRES_BIT = 1;
  localparam int IRQ_W = 2;
  // Reset values
  localparam logic [15:0] PER_RST = 16'h00FF;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  // ==========================================================================
  // Pin pair travelling together
  typedef struct packed {
    logic high;
    logic low;
  } cpg_pair_t;
endpackage : cpg_pkg

// file: design/cpg_top.sv
// Decided for this implementation: the Wishbone register port and the address map.
`timescale 1ns/10ps
module cpg_top #(
  parameter int CNT_W = 16 // Counter width
) (
  input wire logic clk_i, // 100 MHz clock
  input wire logic rst_i, // Sync reset, active high
  input wire logic [31:0] wb_adr_i, // Wishbone address
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  input wire logic [3:0] wb_sel_i, // Byte selects
  input wire logic wb_we_i, // Write enable
  input wire logic wb_cyc_i, // Cycle
  input wire logic wb_stb_i, // Strobe
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Acknowledge
  input wire logic cur_reset_i, // External current-reset pin
  input wire logic master_sync_i, // Master time base period start
  output logic high_side_output_o, // High-side gate
  output logic low_side_output_o, // Low-side gate
  output logic irq_o // Level interrupt
);
  // ==========================================================================
  // Parameter check
  initial begin
    if (CNT_W < 4 || CNT_W > 16) begin
      $error("CNT_W out of range");
    end
  end

  // ==========================================================================
  // State
  logic [15:0] ctrl_reg, ctrl_next;
  logic [15:0] per_reg, per_next;
  logic [15:0] duty_reg, duty_next;
  logic [15:0] dtp_reg, dtp_next;
  logic [15:0] dta_reg, dta_next;
  logic [15:0] ioc_reg, ioc_next;
  logic [1:0] oven_reg, oven_next; // Effective override enables
  localparam int IRQ_W_C = cpg_pkg::IRQ_W;
  logic [IRQ_W_C-1:0] stat_reg, stat_next;
  logic [IRQ_W_C-1:0] ien_reg, ien_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic dir_reg, dir_next; // Centre mode: 1 = counting down
  logic [CNT_W-1:0] dt_reg, dt_next; // Dead-time counter
  logic raw_h_reg, raw_h_next; // Ideal high before dead time
  logic alt_reg, alt_next; // Current reset every other trip
  logic [1:0] cr_sync_reg, ms_sync_reg;
  logic cr_prev_reg;
  cpg_pkg::cpg_pair_t out_reg, out_next;
  logic [31:0] rdat_reg, rdat_next;
  logic ack_reg, ack_next;
  logic irq_reg, irq_next;

  // ==========================================================================
  // Helpers
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : merge16

  logic wr, rd, en, center, independent_time_base_bit, dt_busy, cr_edge, per_end;
  logic [7:0] adr;
  logic [CNT_W-1:0] duty_c, per_c, dta_c, dtp_c;
  always_comb begin
    adr = wb_adr_i[7:0];
    wr = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_reg;
    rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~ack_reg;
    en = ctrl_reg[cpg_pkg::CTRL_EN_BIT];
    center = ctrl_reg[cpg_pkg::CTRL_CENTER_BIT];
    independent_time_base_bit = ctrl_reg[cpg_pkg::CTRL_ITB_BIT];
    duty_c = duty_reg[CNT_W-1:0];
    per_c = per_reg[CNT_W-1:0];
    dta_c = dta_reg[CNT_W-1:0];
    dtp_c = dtp_reg[CNT_W-1:0];
    dt_busy = dt_reg != '0;
    cr_edge = cr_sync_reg[1] & ~cr_prev_reg;
    // Period end: own counter with INDEPENDENT_TIME_BASE_BIT, master sync pulse otherwise
    per_end = independent_time_base_bit ? (center ? (dir_reg && cnt_reg == '0) : (cnt_reg >= per_c)) : ms_sync_reg[1];
  end

  // ==========================================================================
  // Input synchronisers; first stage read only by second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cr_sync_reg <= 2'b00;
      ms_sync_reg <= 2'b00;
      cr_prev_reg <= 1'b0;
    end else begin
      cr_sync_reg <= {cr_sync_reg[0], cur_reset_i};
      ms_sync_reg <= {ms_sync_reg[0], master_sync_i};
      cr_prev_reg <= cr_sync_reg[1];
    end
  end

  // ==========================================================================
  // Register file next values; one-cycle ack
  always_comb begin
    ctrl_next = ctrl_reg;
    per_next = per_reg;
    duty_next = duty_reg;
    dtp_next = dtp_reg;
    dta_next = dta_reg;
    ioc_next = ioc_reg;
    ien_next = ien_reg;
    oven_next = oven_reg;
    ack_next = (wb_cyc_i & wb_stb_i) & ~ack_reg;
    rdat_next = rdat_reg;
    stat_next = stat_reg;
    if (wr) begin
      if (adr == cpg_pkg::CTRL_OFS) begin
        ctrl_next = merge16(ctrl_reg, wb_dat_i, wb_sel_i);
      end else if (adr == cpg_pkg::PER_OFS) begin
        per_next = merge16(per_reg, wb_dat_i, wb_sel_i);
      end else if (adr == cpg_pkg::DUTY_OFS) begin
        duty_next = merge16(duty_reg, wb_dat_i, wb_sel_i);
      end else if (adr == cpg_pkg::DTP_OFS) begin
        dtp_next = merge16(dtp_reg, wb_dat_i, wb_sel_i);
      end else if (adr == cpg_pkg::DTA_OFS) begin
        dta_next = merge16(dta_reg, wb_dat_i, wb_sel_i);
      end else if (adr == cpg_pkg::IOC_OFS) begin
        ioc_next = merge16(ioc_reg, wb_dat_i, wb_sel_i);
      end else if (adr == cpg_pkg::ICLR_OFS && wb_sel_i[0]) begin
        stat_next = stat_reg & ~wb_dat_i[IRQ_W_C-1:0];
      end else if (adr == cpg_pkg::IEN_OFS && wb_sel_i[0]) begin
        ien_next = wb_dat_i[IRQ_W_C-1:0];
      end
    end
    // Events set after clear so a coincident event wins
    if (en && per_end) begin
      stat_next[cpg_pkg::IRQ_PERIOD_BIT] = 1'b1;
    end
    // Current-limit event is silent with INDEPENDENT_TIME_BASE_BIT current reset
    if (cr_edge && !(independent_time_base_bit && ctrl_reg[cpg_pkg::CTRL_XRES_BIT])) begin
      stat_next[cpg_pkg::IRQ_XRES_BIT] = 1'b1;
    end
    // Override enables: sync to period end or take at once
    if (ioc_reg[cpg_pkg::IOC_SYNC_BIT] == 1'b0 || per_end || !en) begin
      // Release ignored during dead time unless module disabled
      if (!(en && dt_busy && ioc_reg[cpg_pkg::IOC_OVEN_LSB +: 2] == 2'b00)) begin
        oven_next = ioc_reg[cpg_pkg::IOC_OVEN_LSB +: 2];
      end
    end
    if (rd) begin
      if (adr == cpg_pkg::CTRL_OFS) begin
        rdat_next = {16'h0000, ctrl_reg};
      end else if (adr == cpg_pkg::PER_OFS) begin
        rdat_next = {16'h0000, per_reg};
      end else if (adr == cpg_pkg::DUTY_OFS) begin
        rdat_next = {16'h0000, duty_reg};
      end else if (adr == cpg_pkg::DTP_OFS) begin
        rdat_next = {16'h0000, dtp_reg};
      end else if (adr == cpg_pkg::DTA_OFS) begin
        rdat_next = {16'h0000, dta_reg};
      end else if (adr == cpg_pkg::IOC_OFS) begin
        rdat_next = {16'h0000, ioc_reg};
      end else if (adr == cpg_pkg::STAT_OFS) begin
        rdat_next = {30'h0000_0000, stat_reg};
      end else if (adr == cpg_pkg::IEN_OFS) begin
        rdat_next = {30'h0000_0000, ien_reg};
      end else if (adr == cpg_pkg::CNT_OFS) begin
        rdat_next = 32'(cnt_reg);
      end else begin
        rdat_next = 32'h0000_0000; // Unmapped reads zero
      end
    end
    irq_next = |(stat_next & ien_next);
  end

  // ==========================================================================
  // Time base, ideal waveform, dead time and outputs
  always_comb begin
    cnt_next = cnt_reg;
    dir_next = dir_reg;
    alt_next = alt_reg;
    raw_h_next = raw_h_reg;
    dt_next = dt_busy ? dt_reg - 1'b1 : dt_reg;
    out_next = out_reg;
    if (!en) begin
      cnt_next = '0;
      dir_next = 1'b0;
      raw_h_next = 1'b0;
      dt_next = '0;
      out_next = '0;
    end else begin
      // Current reset honoured only on alternate trips with INDEPENDENT_TIME_BASE_BIT
      if (independent_time_base_bit && ctrl_reg[cpg_pkg::CTRL_XRES_BIT] && cr_edge) begin
        alt_next = ~alt_reg;
        if (alt_reg) begin
          cnt_next = '0;
          dir_next = 1'b0;
        end
      end else if (per_end) begin
        cnt_next = '0;
        dir_next = 1'b0;
      end else if (center) begin
        if (!dir_reg && cnt_reg >= per_c) begin
          dir_next = 1'b1;
          cnt_next = cnt_reg - 1'b1;
        end else begin
          cnt_next = dir_reg ? cnt_reg - 1'b1 : cnt_reg + 1'b1;
        end
      end else begin
        cnt_next = cnt_reg + 1'b1;
      end
      // Immediate compare on live duty; buffered duty would wait
      // Centre compare widened by a bit so duty above the period never wraps
      raw_h_next = center ? ({1'b0, cnt_next} + {1'b0, duty_c} > {1'b0, per_c}) : (cnt_next < duty_c);
      if (raw_h_next != raw_h_reg) begin
        // Dead time restarts on each edge; a duty write mid-dead-time that flips the waveform restarts it
        dt_next = raw_h_next ? dtp_c : dta_c;
        out_next = '0;
        // Immediate-update jump lands with no dead time
        if (ctrl_reg[cpg_pkg::CTRL_IMM_BIT] && wr && adr == cpg_pkg::DUTY_OFS) begin
          dt_next = '0;
          out_next.high = raw_h_next;
          out_next.low = ~raw_h_next;
        end
      end else if (!dt_busy) begin
        // Dead time re-inserted each period unless cleared, so 0%/100% hold solid only with it cleared
        out_next.high = raw_h_reg;
        out_next.low = ~raw_h_reg;
        // Tiny centre duty below half alt dead time keeps low off with INDEPENDENT_TIME_BASE_BIT
        if (center && independent_time_base_bit && (duty_c < (dta_c >> 1))) begin
          out_next.low = 1'b0;
        end
      end
      // Centre re-arms on alt dead time only, so clearing it gives solid 0%/100%
      if (per_end && (center ? dta_c != '0 : (dtp_c | dta_c) != '0) && (duty_c == '0 || duty_c == per_c)) begin
        dt_next = center ? dta_c : ((dtp_c > dta_c) ? dtp_c : dta_c);
        out_next = '0;
      end
      // Override: enables bit1 high, bit0 low; data bit1 high, bit0 low
      if (oven_reg[1]) begin
        out_next.high = ioc_reg[cpg_pkg::IOC_OVD_LSB + 1];
      end
      if (oven_reg[0]) begin
        out_next.low = ioc_reg[cpg_pkg::IOC_OVD_LSB];
      end
    end
  end

  // ==========================================================================
  // All state registers except the input synchronisers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= cpg_pkg::CTRL_RST;
      per_reg <= cpg_pkg::PER_RST;
      duty_reg <= 16'h0000;
      dtp_reg <= 16'h0000;
      dta_reg <= 16'h0000;
      ioc_reg <= 16'h0000;
      oven_reg <= 2'b00;
      stat_reg <= '0;
      ien_reg <= '0;
      cnt_reg <= '0;
      dir_reg <= 1'b0;
      dt_reg <= '0;
      raw_h_reg <= 1'b0;
      alt_reg <= 1'b0;
      out_reg <= '0;
      rdat_reg <= 32'h0000_0000;
      ack_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      per_reg <= per_next;
      duty_reg <= duty_next;
      dtp_reg <= dtp_next;
      dta_reg <= dta_next;
      ioc_reg <= ioc_next;
      oven_reg <= oven_next;
      stat_reg <= stat_next;
      ien_reg <= ien_next;
      cnt_reg <= cnt_next;
      dir_reg <= dir_next;
      dt_reg <= dt_next;
      raw_h_reg <= raw_h_next;
      alt_reg <= alt_next;
      out_reg <= out_next;
      rdat_reg <= rdat_next;
      ack_reg <= ack_next;
      irq_reg <= irq_next;
    end
  end

  assign wb_dat_o = rdat_reg;
  assign wb_ack_o = ack_reg;
  assign high_side_output_o = out_reg.high;
  assign low_side_output_o = out_reg.low;
  assign irq_o = irq_reg;

  // ==========================================================================
  // Checks
  chk_no_shoot_through: assert property (@(posedge clk_i) disable iff (rst_i)
    !(out_reg.high && out_reg.low && oven_reg == 2'b00)) else $error("Both outputs high");
  chk_dead_gap: assert property (@(posedge clk_i) disable iff (rst_i)
    (en && oven_reg == 2'b00 && !$past(wr) && $rose(out_reg.high)) |-> $past(!out_reg.low))
    else $error("No gap before high");
  chk_cr_alternate: assert property (@(posedge clk_i) disable iff (rst_i)
    (en && independent_time_base_bit && ctrl_reg[cpg_pkg::CTRL_XRES_BIT] && cr_edge && !alt_reg) |=> alt_reg)
    else $error("Alternate flag stuck");
  chk_no_cl_irq: assert property (@(posedge clk_i) disable iff (rst_i)
    (independent_time_base_bit && ctrl_reg[cpg_pkg::CTRL_XRES_BIT] && !stat_reg[cpg_pkg::IRQ_XRES_BIT] && !wr)
    |=> !stat_reg[cpg_pkg::IRQ_XRES_BIT]) else $error("Current-limit flag set");
  chk_ovr_data: assert property (@(posedge clk_i) disable iff (rst_i)
    (en && oven_reg == 2'b11) |=> out_reg == $past(ioc_reg[7:6]))
    else $error("Override data not driven");
  chk_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o) else $error("Ack held");
  chk_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_o == |($past(stat_next) & $past(ien_next))) else $error("Irq mismatch");
  chk_tiny_duty: assert property (@(posedge clk_i) disable iff (rst_i)
    (en && center && independent_time_base_bit && oven_reg == 2'b00 && duty_c < (dta_c >> 1)) ##1 (en && center && independent_time_base_bit && oven_reg == 2'b00 && duty_c < (dta_c >> 1) && !dt_busy) |-> !out_reg.low)
    else $error("Low asserted at tiny duty");
endmodule : cpg_top

// file: tb/cpg_stage_model.sv
`timescale 1ns/10ps
// ========
// Gate driver pair and current comparator seen from the block's pins
module cpg_stage_model (
  input wire logic clk_i, // 100 MHz clock
  input wire logic rst_i, // Sync reset, active high
  input wire logic high_i, // High-side gate drive
  input wire logic low_i, // Low-side gate drive
  input wire logic trip_i, // Bench asks for one comparator trip
  input wire logic sync_en_i, // Bench runs the master time base
  output logic cur_reset_o, // Comparator trip pulse
  output logic master_sync_o, // Master period start pulse
  output logic [15:0] overlap_o // Cycles with both gates on
);
  logic [4:0] div_reg;
  // One-clock trip: 10 ns stays under the narrowest pulse limit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur_reset_o <= 1'b0;
      master_sync_o <= 1'b0;
      div_reg <= 5'h00;
      overlap_o <= 16'h0000;
    end else begin
      cur_reset_o <= trip_i;
      div_reg <= div_reg + 5'h01;
      master_sync_o <= sync_en_i && (div_reg == 5'h1F);
      // Shoot-through would short the supply, so every such cycle counts
      if (high_i && low_i) begin
        overlap_o <= overlap_o + 16'h0001;
      end
    end
  end
endmodule : cpg_stage_model

// file: tb/complementary_pwm_deadtime_generator_bench.sv
`timescale 1ns/10ps
// ========
// Self-checking bench for the gate pair generator
module complementary_pwm_deadtime_generator_bench;
  localparam logic [15:0] PER = 16'h0028;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [31:0] wb_adr_i = 32'h0000_0000;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic wb_we_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic trip = 1'b0;
  logic sync_en = 1'b0;
  logic [31:0] wb_dat_o, rd, a;
  logic wb_ack_o, cur_rst, msync, hs, ls, irq;
  logic [15:0] overlap;
  int fails = 0;
  int cmp_count = 0;
  int hi_n, lo_n, g_hl, g_lh, resets;
  logic [15:0] dv [4] = '{PER + 16'h0001, 16'h0000, PER + 16'h0002, 16'h0000};

  // Free-running clock
  always #5 clk_i = ~clk_i;

  cpg_top #(.CNT_W(16)) DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(4'hF), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .cur_reset_i(cur_rst), .master_sync_i(msync), .high_side_output_o(hs),
    .low_side_output_o(ls), .irq_o(irq));

  cpg_stage_model stage (.clk_i(clk_i), .rst_i(rst_i), .high_i(hs), .low_i(ls), .trip_i(trip),
    .sync_en_i(sync_en), .cur_reset_o(cur_rst), .master_sync_o(msync), .overlap_o(overlap));

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  // Classic cycle: held until ack is sampled, then released for a cycle
  task automatic xfer(input logic [7:0] ad, input logic [31:0] d, input logic we);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {24'h00_0000, ad};
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 16);
    if (n >= 16) fails++;
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    xfer(ad, d, 1'b1);
  endtask : wr

  task automatic rdc(input logic [7:0] ad, input logic [31:0] exp);
    xfer(ad, 32'h0000_0000, 1'b0);
    cmp(rd, exp);
  endtask : rdc

  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : idle

  // Stop, load, restart, then wait 100 cycles
  task automatic cfg(input logic [15:0] c, p, d, dp, da);
    wr(cpg_pkg::CTRL_OFS, 32'h0000_0000);
    wr(cpg_pkg::PER_OFS, {16'h0000, p});
    wr(cpg_pkg::DUTY_OFS, {16'h0000, d});
    wr(cpg_pkg::DTP_OFS, {16'h0000, dp});
    wr(cpg_pkg::DTA_OFS, {16'h0000, da});
    wr(cpg_pkg::CTRL_OFS, {16'h0000, c});
    idle(100);
  endtask : cfg

  // Counts on-cycles and the shortest off gap before each gate turns on
  task automatic watch(input int n);
    int th, tl;
    logic ph, pl;
    th = -1;
    tl = -1;
    hi_n = 0;
    lo_n = 0;
    g_hl = 999;
    g_lh = 999;
    ph = hs;
    pl = ls;
    for (int k = 0; k < n; k++) begin
      @(posedge clk_i);
      #1;
      hi_n += int'(hs);
      lo_n += int'(ls);
      if (ph && !hs) th = k;
      if (pl && !ls) tl = k;
      if (!pl && ls && th >= 0 && k - th < g_hl) g_hl = k - th;
      if (!ph && hs && tl >= 0 && k - tl < g_lh) g_lh = k - tl;
      ph = hs;
      pl = ls;
    end
  endtask : watch

  task automatic t_reset;
    rdc(cpg_pkg::CTRL_OFS, 32'h0000_0000);
    rdc(cpg_pkg::PER_OFS, 32'h0000_00FF);
    rdc(8'h3C, 32'h0000_0000);
    cmp({hs, ls, irq}, 32'h0000_0000);
  endtask : t_reset

  task automatic t_dead;
    cfg(16'h8200, PER, 16'h0014, 16'h0004, 16'h0006);
    watch(200);
    cmp(g_lh >= 4 && g_lh < 40, 1'b1);
    cmp(g_hl >= 6 && g_hl < 40, 1'b1);
    cfg(16'h8200, PER, 16'h0000, 16'h0004, 16'h0004);
    watch(200);
    cmp(lo_n < 200, 1'b1);
    cfg(16'h8200, PER, PER, 16'h0004, 16'h0004);
    watch(200);
    cmp(hi_n < 200, 1'b1);
  endtask : t_dead

  // Edge then centre: full and zero duty; both dead times cleared in edge, only alt in centre
  task automatic t_full;
    for (int i = 0; i < 4; i++) begin
      cfg(i < 2 ? 16'h8200 : 16'h8204, PER, dv[i], i < 2 ? 16'h0000 : 16'h0003, 16'h0000);
      watch(200);
      cmp(i % 2 ? lo_n : hi_n, 200);
    end
  endtask : t_full

  task automatic t_override;
    cfg(16'h8200, PER, 16'h0014, 16'h0004, 16'h0004);
    wr(cpg_pkg::IOC_OFS, 32'h0000_0341);
    idle(100);
    watch(80);
    cmp(hi_n, 32'd0);
    cmp(lo_n, 32'd80);
    wr(cpg_pkg::IOC_OFS, 32'h0000_0381);
    idle(100);
    watch(80);
    cmp(hi_n, 32'd80);
    cmp(lo_n, 32'd0);
    wr(cpg_pkg::CTRL_OFS, 32'h0000_0000);
    wr(cpg_pkg::IOC_OFS, 32'h0000_0000);
    wr(cpg_pkg::CTRL_OFS, 32'h0000_8200);
    idle(100);
    watch(200);
    cmp(hi_n > 0 && lo_n > 0, 1'b1);
  endtask : t_override

  task automatic t_irq;
    wr(cpg_pkg::IEN_OFS, 32'h0000_0001);
    idle(100);
    cmp(irq, 1'b1);
    wr(cpg_pkg::IEN_OFS, 32'h0000_0000);
    idle(3);
    cmp(irq, 1'b0);
    wr(cpg_pkg::CTRL_OFS, 32'h0000_0000);
    wr(cpg_pkg::ICLR_OFS, 32'h0000_0003);
    rdc(cpg_pkg::STAT_OFS, 32'h0000_0000);
  endtask : t_irq

  // Trips four times; with the long period only a reset lowers the count
  task automatic t_xres;
    cfg(16'h8202, 16'h0FFF, 16'h0800, 16'h0004, 16'h0004);
    resets = 0;
    repeat (4) begin
      xfer(cpg_pkg::CNT_OFS, 32'h0000_0000, 1'b0);
      a = rd;
      @(posedge clk_i);
      trip <= 1'b1;
      @(posedge clk_i);
      trip <= 1'b0;
      idle(10);
      xfer(cpg_pkg::CNT_OFS, 32'h0000_0000, 1'b0);
      if (rd < a) resets++;
    end
    cmp(resets, 2);
    xfer(cpg_pkg::STAT_OFS, 32'h0000_0000, 1'b0);
    cmp(rd[1], 1'b0);
    // Interrupt-style period dip below duty, then restore and clear the flag
    wr(cpg_pkg::PER_OFS, 32'h0000_07FF);
    wr(cpg_pkg::PER_OFS, 32'h0000_0FFF);
    wr(cpg_pkg::ICLR_OFS, 32'h0000_0001);
  endtask : t_xres

  task automatic t_master;
    sync_en <= 1'b1;
    cfg(16'h8000, 16'h0FFF, 16'h0800, 16'h0004, 16'h0004);
    repeat (3) begin
      xfer(cpg_pkg::CNT_OFS, 32'h0000_0000, 1'b0);
      cmp(rd < 40, 1'b1);
      idle(7);
    end
    sync_en <= 1'b0;
  endtask : t_master

  task automatic wrap_up;
    $display("mismatches %0d comparisons %0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up

  // Main sequence
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_dead;
    t_full;
    t_override;
    t_irq;
    t_xres;
    t_master;
    cmp(overlap, 16'h0000);
    wrap_up;
  end

  // Whole run needs about 3500 cycles; over ten times that means a hang
  initial begin
    #400000;
    fails++;
    wrap_up;
  end
endmodule : complementary_pwm_deadtime_generator_bench
